// ---- hw/tes_pkg.sv ----
/*
 * Package for the tape error retry sequencer: step values, bus width,
 * command code and FIFO geometry.
 * Assumes nothing of its surroundings.
 */
package tes_pkg;
  localparam logic [2:0] TES_STEP_ZERO = 3'h0;
  localparam logic [2:0] TES_STEP_ONE = 3'h1;
  localparam logic [2:0] TES_STEP_SIX = 3'h6;
  localparam logic [2:0] TES_STEP_SEVEN = 3'h7;
  localparam logic [2:0] TES_STC_FULL = 3'h3;
  localparam logic [7:0] TES_CMD_MINUS_ONE = 8'hCD;
  localparam int TES_BUS_W = 48;
  localparam int TES_ADDR_W = 15;
  localparam int TES_FIFO_DEPTH = 32;
  localparam logic TES_DIR_FWD = 1'b1;
endpackage : tes_pkg

// ---- hw/tes_fifo.sv ----
/*
 * Synchronous FIFO in flip-flops carrying words toward memory.
 * Assumes one clock and a synchronous active low reset.
 */
`timescale 1ns/10ps
module tes_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Honest full and empty flags from the occupancy count
  assign wr_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_q != '0);
  assign push = wr_valid_in & wr_ready_out;
  assign pop = rd_valid_out & rd_ready_in;
  assign rd_data_out = mem_q[rp_q];

  // Storage, written only on an accepted push
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_q[wp_q] <= wr_data_in;
    end
  end

  // Pointers and count
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tes_fifo

// ---- hw/tes_seq.sv ----
/*
 * Tape error retry sequencer: mode three write retry and minus-one read.
 * Assumes all phase strobes are one-cycle pulses from logic on sys_clk_in,
 * except the transport hold flags, which come from pins and are synced.
 */
// Functional notes
// - Write error in mode three loads step one and clears change flag.
// - Backspace steps to two; rewrite to three, change back to zero.
// - Successful rewrite clears step at end mark; halt flag stays clear.
// - Failed rewrite halts at block end, step three, change zero.
// - After completion, reverse restart with wipe and start flags set.
// - While wiping, step four, change one, error flags cleared.
// - Wipe done: stop, completion pulse clears wipe, restart forward.
// - Next rewrite targets following block, step goes to five.
// - Persisting error: backspace step six, rewrite step seven.
// - Second failure wipes in reverse, step zero, no restart.
// - Every rewrite copies address buffer into start address register.
// - Hold matrix at completion while step nonzero or any error, space error included.
// - Minus-one order sets its flag, step six, change zero.
// - Start, move opposite direction, set skip flag when hold sets.
// - Backspace steps seven, change one; no first pass or block count.
// - End mark of backspace clears errors, then halt and clear skip.
// - Restart commanded way, step zero at begin mark, copy address.
// - Hold parity error clear until both timing counters reach three.
// - Full serial buffer with parity error: clear it, set minus-one bit.
// - Minus-one bit clears word buffer, drives only bit zero, minus one.
// - Minus-one order halts at block end, clears flag after completion.
// - At termination parity error reads zero, sprocket error retained.
// - Change flag steps at begin phase three while step nonzero.
`timescale 1ns/10ps
module tes_seq
  import tes_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic mode_three_write_in,
  input wire logic cmd_dir_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic order_accept_signal_in,
  input wire logic begin_mark_phase_one_in,
  input wire logic begin_mark_phase_three_in,
  input wire logic end_mark_phase_one_in,
  input wire logic finis_in,
  input wire logic phase_two_in,
  input wire logic parity_err_in,
  input wire logic sprocket_err_in,
  input wire logic space_err_in,
  input wire logic fwd_hold_pin_in,
  input wire logic rev_hold_pin_in,
  input wire logic [2:0] sprocket_timing_counter_a_in,
  input wire logic [2:0] sprocket_timing_counter_b_in,
  input wire logic shift_set_in,
  input wire logic sprocket_subphase_two_in,
  input wire logic [TES_BUS_W-1:0] serial_buffer_register_in,
  input wire logic word_load_in,
  input wire logic advance_start_address_signal_in,
  input wire logic [TES_ADDR_W-1:0] current_address_buffer_in,
  input wire logic mem_ready_in,
  output logic [TES_BUS_W-1:0] memory_transfer_bus_out,
  output logic memory_transfer_valid_out,
  output logic word_ready_out,
  output logic start_out,
  output logic tape_dir_out,
  output logic halt_at_block_end_flag_out,
  output logic skip_block_flag_out,
  output logic wipe_block_flag_out,
  output logic first_pass_out,
  output logic block_count_primary_dec_out,
  output logic release_matrix_out,
  output logic [2:0] retry_step_counter_out,
  output logic direction_change_flag_out,
  output logic minus_one_read_out,
  output logic parity_err_out,
  output logic sprocket_err_out,
  output logic [TES_ADDR_W-1:0] start_address_high_register_out
);
  logic [2:0] step_q;
  logic chg_q, halt_q, skip_q, wipe_q, m1_q, m1bit_q, perr_q, serr_q;
  logic start_q, dir_q, shift_q, rel_q, wbr_v_q;
  logic [TES_ADDR_W-1:0] csa_q;
  logic [TES_BUS_W-1:0] wbr_q;
  logic fh_s1_q, fh_s2_q, rh_s1_q, rh_s2_q;
  logic m1_accept, load_one, load_six, step_pulse, retry, any_err;
  logic fifo_ready;

  //////////////////////////////////////////////////////////////////////
  // Hold flags arrive from the transport pins; two flops before use
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      fh_s1_q <= 1'b0;
      fh_s2_q <= 1'b0;
      rh_s1_q <= 1'b0;
      rh_s2_q <= 1'b0;
    end else begin
      fh_s1_q <= fwd_hold_pin_in;
      fh_s2_q <= fh_s1_q;
      rh_s1_q <= rev_hold_pin_in;
      rh_s2_q <= rh_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Decode of the load events
  assign m1_accept = order_accept_signal_in &
                     (cmd_code_in == TES_CMD_MINUS_ONE);
  assign any_err = perr_q | serr_q;
  // Only the first error of a pass loads one; later ones are in retry
  assign load_one = mode_three_write_in & ~m1_q & (step_q == TES_STEP_ZERO)
                    & ~halt_q & (parity_err_in | sprocket_err_in);
  assign load_six = m1_accept;
  assign retry = (step_q != TES_STEP_ZERO);
  assign step_pulse = begin_mark_phase_one_in & retry;

  //////////////////////////////////////////////////////////////////////
  // Retry step counter; three bits, so seven wraps to zero by itself
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      step_q <= TES_STEP_ZERO;
    end else if (load_six) begin
      step_q <= TES_STEP_SIX;
    end else if (load_one) begin
      step_q <= TES_STEP_ONE;
    end else if (step_pulse) begin
      // 1->2 backspace, 2->3 rewrite, 3->4 wipe, 4->5 next block,
      // 5->6 backspace, 6->7 rewrite, 7->0 final wipe or m1 re-read
      step_q <= step_q + 3'h1;
    end else if (end_mark_phase_one_in & ~skip_q & ~wipe_q & ~any_err
                 & ~m1_q & mode_three_write_in & retry) begin
      step_q <= TES_STEP_ZERO;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Direction change flag: cleared on loads, toggled at phase three
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      chg_q <= 1'b0;
    end else if (load_six | load_one) begin
      chg_q <= 1'b0;
    end else if (begin_mark_phase_three_in & retry) begin
      chg_q <= ~chg_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Halt-at-block-end: set by retry or order, cleared on clean end mark
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      halt_q <= 1'b0;
    end else if (end_mark_phase_one_in & ~any_err & ~skip_q & ~wipe_q
                 & ~m1_q) begin
      // Clean end mark wins; the step clears on the same edge, so no re-set
      halt_q <= 1'b0;
    end else if (retry | wipe_q | m1_q) begin
      halt_q <= 1'b1;
    end else if (finis_in) begin
      halt_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Start and direction. Change flag zero moves opposite the command.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      start_q <= 1'b0;
      dir_q <= TES_DIR_FWD;
    end else if (m1_accept) begin
      start_q <= 1'b1;
      dir_q <= ~cmd_dir_in;
    end else if (finis_in) begin
      // Step zero after a wipe means the order ends without motion
      start_q <= retry;
      dir_q <= chg_q ? cmd_dir_in : ~cmd_dir_in;
    end else if (load_one) begin
      start_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Wipe flag: set with restart after a failed rewrite, cleared at finis
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      wipe_q <= 1'b0;
    end else if (finis_in & wipe_q) begin
      wipe_q <= 1'b0;
    end else if (finis_in & mode_three_write_in & any_err &
                 ((step_q == 3'h3) | (step_q == TES_STEP_SEVEN))) begin
      wipe_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Skip flag on the minus-one backspace, dropped when tape stops
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      skip_q <= 1'b0;
    end else if (finis_in) begin
      skip_q <= 1'b0;
    end else if (m1_q & ~chg_q & retry & (fh_s2_q | rh_s2_q)) begin
      skip_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Minus-one order flag, cleared at the phase two after finis
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      m1_q <= 1'b0;
      rel_q <= 1'b0;
    end else begin
      if (m1_accept) begin
        m1_q <= 1'b1;
      end else if (phase_two_in & rel_q) begin
        m1_q <= 1'b0;
      end
      // Marks the finis that ends the re-read pass
      if (finis_in & m1_q & ~retry) begin
        rel_q <= 1'b1;
      end else if (phase_two_in) begin
        rel_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Shift flag guards the parity hold after the first full buffer
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      shift_q <= 1'b0;
    end else if (begin_mark_phase_one_in) begin
      shift_q <= 1'b0;
    end else if (shift_set_in) begin
      shift_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Error flags; a new error wins over a clear in the same cycle, except the wipe clear and the minus-one parity hold
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      perr_q <= 1'b0;
      serr_q <= 1'b0;
    end else begin
      if (wipe_q | (m1_q & ~retry & ~shift_q &
          ((sprocket_timing_counter_a_in != TES_STC_FULL) |
           (sprocket_timing_counter_b_in != TES_STC_FULL)))) begin
        perr_q <= 1'b0;
      end else if (parity_err_in) begin
        perr_q <= 1'b1;
      end else if (m1_q & sprocket_subphase_two_in) begin
        perr_q <= 1'b0;
      end else if (end_mark_phase_one_in & (skip_q | (chg_q & retry))) begin
        perr_q <= 1'b0;
      end else if (rel_q) begin
        perr_q <= 1'b0;
      end
      if (wipe_q) begin
        serr_q <= 1'b0;
      end else if (sprocket_err_in) begin
        serr_q <= 1'b1;
      end else if (end_mark_phase_one_in & (skip_q | (chg_q & retry))) begin
        serr_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Minus-one bit: set on a flagged full buffer, cleared by the count
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      m1bit_q <= 1'b0;
    end else if (m1_q & sprocket_subphase_two_in & perr_q) begin
      m1bit_q <= 1'b1;
    end else if (advance_start_address_signal_in) begin
      m1bit_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Start address copy on every rewrite and on the minus-one passes
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      csa_q <= '0;
    end else if (begin_mark_phase_three_in & (retry | m1_q) & ~wipe_q) begin
      csa_q <= current_address_buffer_in;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Word buffer; the minus-one bit substitutes 48'h1 for the data.
  // Stalls (word_ready_out low) while the FIFO is full.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      wbr_q <= '0;
      wbr_v_q <= 1'b0;
    end else if (wbr_v_q & fifo_ready) begin
      wbr_v_q <= 1'b0;
    end else if (word_load_in & ~wbr_v_q) begin
      // Cleared buffer with only bit zero driven, upper bits zero
      wbr_q <= m1bit_q ? TES_BUS_W'(1) : serial_buffer_register_in;
      wbr_v_q <= 1'b1;
    end
  end
  assign word_ready_out = ~wbr_v_q;

  // Queue toward memory, so a memory stall does not lose tape data
  tes_fifo #(
    .WIDTH(TES_BUS_W),
    .DEPTH(TES_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .wr_data_in(wbr_q),
    .wr_valid_in(wbr_v_q),
    .wr_ready_out(fifo_ready),
    .rd_data_out(memory_transfer_bus_out),
    .rd_valid_out(memory_transfer_valid_out),
    .rd_ready_in(mem_ready_in)
  );

  //////////////////////////////////////////////////////////////////////
  // Outputs
  assign release_matrix_out = finis_in & ~retry & ~any_err & ~m1_q
                              & ~wipe_q & ~space_err_in;
  assign retry_step_counter_out = step_q;
  assign direction_change_flag_out = chg_q;
  assign start_out = start_q;
  assign tape_dir_out = dir_q;
  assign halt_at_block_end_flag_out = halt_q;
  assign skip_block_flag_out = skip_q;
  assign wipe_block_flag_out = wipe_q;
  assign minus_one_read_out = m1_q;
  assign parity_err_out = perr_q;
  assign sprocket_err_out = serr_q;
  assign start_address_high_register_out = csa_q;
  assign first_pass_out = 1'b0;
  assign block_count_primary_dec_out = begin_mark_phase_one_in & ~retry
                                       & ~m1_q & ~wipe_q;

  //////////////////////////////////////////////////////////////////////
  // Assertions
  property p_load_one;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      load_one & ~load_six |=> (step_q == 3'h1) && !chg_q;
  endproperty
  a_load_one: assert property (p_load_one) else $error("step not one");

  property p_load_six;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      m1_accept |=> (step_q == 3'h6) && !chg_q && m1_q && start_q;
  endproperty
  a_load_six: assert property (p_load_six) else $error("m1 load wrong");

  property p_step;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      step_pulse & ~load_one & ~load_six |=> step_q == $past(step_q) + 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("step not advanced");

  property p_matrix;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      retry | perr_q |-> !release_matrix_out;
  endproperty
  a_matrix: assert property (p_matrix) else $error("matrix released");

  property p_m1bit;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      m1_q & sprocket_subphase_two_in & perr_q |=> m1bit_q;
  endproperty
  a_m1bit: assert property (p_m1bit) else $error("m1 bit not set");

  property p_wipe_clear;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      wipe_q ##1 wipe_q |-> !perr_q && !serr_q;
  endproperty
  a_wipe_clear: assert property (p_wipe_clear) else $error("errors kept");

  property p_wipe_end;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      finis_in & wipe_q |=> !wipe_q;
  endproperty
  a_wipe_end: assert property (p_wipe_end) else $error("wipe stuck");

  property p_word;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      word_load_in & ~wbr_v_q & m1bit_q |=> wbr_q == TES_BUS_W'(1);
  endproperty
  a_word: assert property (p_word) else $error("minus one word wrong");
endmodule : tes_seq

// ---- sim/tes_tape_model.sv ----
/*
 * Far side model for tes_seq: tape transport hold pins and memory side
 * acceptance of FIFO words.
 * Assumes the bench drives stall_in and the sequencer drives start and dir.
 */
`timescale 1ns/10ps
module tes_tape_model (
  input wire logic sys_clk_in,
  input wire logic start_in,
  input wire logic dir_in,
  input wire logic stall_in,
  output logic fwd_hold_out,
  output logic rev_hold_out,
  output logic mem_ready_out
);
  logic [1:0] spin_q = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Transport needs a few cycles to reach speed, so hold lags start
  always_ff @(posedge sys_clk_in) begin
    if (!start_in) begin
      spin_q <= 2'h0;
    end else if (spin_q != 2'h3) begin
      spin_q <= spin_q + 2'h1;
    end
  end

  // Hold drops on the first clock after start falls; no stale level is kept
  assign fwd_hold_out = (spin_q == 2'h3) && dir_in;
  assign rev_hold_out = (spin_q == 2'h3) && !dir_in;
  // Memory stalls only when the bench asks, to back up the FIFO
  assign mem_ready_out = !stall_in;
endmodule : tes_tape_model

// ---- sim/tes_seq_test.sv ----
/*
 * Self-checking bench for tes_seq: write retry, minus-one read, FIFO.
 * Assumes tes_tape_model as the transport and memory side.
 */
`timescale 1ns/10ps
module tes_seq_test;
  import tes_pkg::*;
  // Strobe map: 0 bm1, 1 bm3, 2 em1, 3 finis, 4 ph2, 5 parity, 6 sprocket,
  // 7 accept, 8 subphase two, 9 advance start address
  logic sys_clk_in = 1'h0, rst_b_in = 1'h0, m3 = 1'h0, shift = 1'h0;
  logic stall = 1'h0, wload = 1'h0, rel_seen = 1'h0, dec_seen = 1'h0;
  logic [9:0] stb = 10'h0;
  logic cdir = 1'h1;
  logic [7:0] code = 8'h00;
  logic [2:0] sprocket_timing_counter = 3'h0;
  logic [TES_BUS_W-1:0] sdata = 48'h0;
  logic [TES_ADDR_W-1:0] cab = 15'h0;
  logic fh, rh, mrdy, mval, wrdy, start, dir, halt, skip, wipe, fpass;
  logic bdec, rel, chg, m1, perr, serr;
  logic [TES_BUS_W-1:0] bus;
  logic [2:0] step;
  logic [TES_ADDR_W-1:0] csa;
  logic [TES_BUS_W-1:0] got_q[$];
  int failures = 0, num_checks = 0, cycles = 0, n;

  tes_seq u_dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .mode_three_write_in(m3), .cmd_dir_in(cdir), .cmd_code_in(code),
    .order_accept_signal_in(stb[7]), .begin_mark_phase_one_in(stb[0]),
    .begin_mark_phase_three_in(stb[1]), .end_mark_phase_one_in(stb[2]),
    .finis_in(stb[3]), .phase_two_in(stb[4]), .parity_err_in(stb[5]),
    .sprocket_err_in(stb[6]), .space_err_in(1'h0), .fwd_hold_pin_in(fh),
    .rev_hold_pin_in(rh), .sprocket_timing_counter_a_in(sprocket_timing_counter),
    .sprocket_timing_counter_b_in(sprocket_timing_counter), .shift_set_in(shift),
    .sprocket_subphase_two_in(stb[8]), .serial_buffer_register_in(sdata),
    .word_load_in(wload), .advance_start_address_signal_in(stb[9]),
    .current_address_buffer_in(cab), .mem_ready_in(mrdy),
    .memory_transfer_bus_out(bus), .memory_transfer_valid_out(mval),
    .word_ready_out(wrdy), .start_out(start), .tape_dir_out(dir),
    .halt_at_block_end_flag_out(halt), .skip_block_flag_out(skip),
    .wipe_block_flag_out(wipe), .first_pass_out(fpass),
    .block_count_primary_dec_out(bdec), .release_matrix_out(rel),
    .retry_step_counter_out(step), .direction_change_flag_out(chg),
    .minus_one_read_out(m1), .parity_err_out(perr),
    .sprocket_err_out(serr), .start_address_high_register_out(csa));

  tes_tape_model u_tape (.sys_clk_in(sys_clk_in), .start_in(start),
    .dir_in(dir), .stall_in(stall), .fwd_hold_out(fh), .rev_hold_out(rh),
    .mem_ready_out(mrdy));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, cycle ceiling and memory side capture
  initial begin
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) begin
    cycles++;
    if (mval && mrdy) got_q.push_back(bus);
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  // Release and block count are pulses, so watch them every cycle
  always @(negedge sys_clk_in) begin
    if (stb[3] && rel) rel_seen = 1'h1;
    if (bdec) dec_seen = 1'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string nm, input logic [47:0] e,
                     input logic [47:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Each digit of s is one strobe pulse, then time for flags to settle
  task automatic run(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge sys_clk_in) stb[s.getc(i) - 8'h30] <= 1'h1;
      @(posedge sys_clk_in) stb <= 10'h0;
      repeat (3) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
    end
  endtask : run

  task automatic load(input logic [47:0] d);
    @(posedge sys_clk_in);
    wload <= 1'h1;
    sdata <= d;
    @(posedge sys_clk_in) wload <= 1'h0;
    repeat (4) @(negedge sys_clk_in);
  endtask : load

  task automatic do_reset();
    @(posedge sys_clk_in);
    rst_b_in <= 1'h0;
    {m3, sprocket_timing_counter, stall, rel_seen, dec_seen} <= 7'h0;
    repeat (12) @(posedge sys_clk_in);
    rst_b_in <= 1'h1;
    @(negedge sys_clk_in);
    got_q.delete();
  endtask : do_reset

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_idle();
    do_reset();
    chk("step", 48'h0, step);
    chk("dir", 48'h1, dir);
    chk("flags", 48'h0, {start, halt, skip, wipe, m1, perr, serr, chg, mval});
    $display("test idle done");
  endtask : t_idle

  task automatic t_m3_ok();
    do_reset();
    @(posedge sys_clk_in);
    m3 <= 1'h1;
    cab <= 15'h1A5;
    run("5");
    chk("step", 48'h1, step);
    chk("chg", 48'h0, chg);
    run("0");
    chk("step", 48'h2, step);
    run("1");
    chk("chg", 48'h1, chg);
    run("230");
    chk("step", 48'h3, step);
    run("1");
    chk("chg", 48'h0, chg);
    chk("csa", cab, csa);
    run("2");
    chk("step", 48'h0, step);
    chk("halt", 48'h0, halt);
    run("30");
    chk("release", 48'h1, rel_seen);
    chk("halt", 48'h0, halt);
    chk("step", 48'h0, step);
    $display("test m3 success done");
  endtask : t_m3_ok

  task automatic t_m3_fail();
    do_reset();
    @(posedge sys_clk_in);
    m3 <= 1'h1;
    cab <= 15'h2C3;
    run("560123015");
    run("2");
    chk("step halt", 48'h7, {step, halt});
    chk("chg", 48'h0, chg);
    run("3");
    chk("start wipe dir", 48'h6, {start, wipe, dir});
    run("0");
    chk("step", 48'h4, step);
    run("1");
    chk("chg perr serr", 48'h4, {chg, perr, serr});
    run("23");
    chk("start wipe dir", 48'h5, {start, wipe, dir});
    @(posedge sys_clk_in) cab <= 15'h0F0;
    run("0");
    chk("step", 48'h5, step);
    run("1");
    chk("csa", cab, csa);
    run("5230");
    chk("step", 48'h6, step);
    run("1230");
    chk("step", 48'h7, step);
    run("1523");
    chk("wipe dir", 48'h2, {wipe, dir});
    run("0");
    chk("step", 48'h0, step);
    run("123");
    repeat (4) @(negedge sys_clk_in);
    chk("start", 48'h0, start);
    chk("release", 48'h0, rel_seen);
    $display("test m3 failure done");
  endtask : t_m3_fail

  task automatic t_minus_one();
    do_reset();
    @(posedge sys_clk_in);
    code <= TES_CMD_MINUS_ONE;
    cdir <= 1'h0;
    cab <= 15'h3B7;
    run("7");
    chk("m1 step chg", 48'h1C, {m1, step, chg});
    chk("start dir", 48'h3, {start, dir});
    repeat (10) @(negedge sys_clk_in);
    chk("skip", 48'h1, skip);
    run("0");
    chk("step", 48'h7, step);
    run("1");
    chk("chg fpass", 48'h2, {chg, fpass});
    run("52");
    chk("perr", 48'h0, perr);
    run("3");
    repeat (10) @(negedge sys_clk_in);
    chk("skip dir", 48'h0, {skip, dir});
    @(posedge sys_clk_in) cab <= 15'h3C1;
    run("01");
    chk("step csa", {3'h0, 15'h3C1}, {step, csa});
    @(posedge sys_clk_in) sprocket_timing_counter <= 3'h1;
    run("5");
    chk("perr", 48'h0, perr);
    @(posedge sys_clk_in);
    sprocket_timing_counter <= TES_STC_FULL;
    shift <= 1'h1;
    @(posedge sys_clk_in) shift <= 1'h0;
    run("5");
    chk("perr", 48'h1, perr);
    run("8");
    chk("perr", 48'h0, perr);
    load(48'hABCDEF012345);
    chk("minus one", 48'h1, got_q[$]);
    run("9");
    load(48'h123456789ABC);
    chk("word", 48'h123456789ABC, got_q[$]);
    run("623");
    chk("m1", 48'h1, m1);
    run("4");
    chk("m1", 48'h0, m1);
    chk("perr serr", 48'h1, {perr, serr});
    chk("release", 48'h0, rel_seen);
    chk("block count", 48'h0, dec_seen);
    $display("test minus one done");
  endtask : t_minus_one

  task automatic t_fifo();
    do_reset();
    @(posedge sys_clk_in) stall <= 1'h1;
    n = 0;
    while (n < 40 && wrdy === 1'h1) begin
      load(48'(n));
      n++;
    end
    chk("ready", 48'h0, wrdy);
    chk("depth", 48'(TES_FIFO_DEPTH + 1), 48'(n));
    // This load must be refused while the buffer is full
    load(48'hFFFFFFFFFFFF);
    @(posedge sys_clk_in) stall <= 1'h0;
    repeat (100) @(negedge sys_clk_in);
    chk("count", 48'(n), 48'(got_q.size()));
    foreach (got_q[i]) chk("order", 48'(i), got_q[i]);
    chk("empty", 48'h0, mval);
    $display("test fifo done");
  endtask : t_fifo

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; each scenario starts from a fresh reset
  initial begin
    t_idle();
    t_m3_ok();
    t_m3_fail();
    t_minus_one();
    t_fifo();
    test_done();
  end
endmodule : tes_seq_test
